// [hdl/sss_sequencer.sv]
/*
 Power-state sequencer: sleep, standby and active states with driver gate.
 Assumes sleep_pin and strap pins are asynchronous and synchronised here;
 host writes and variant select come from logic on clk_sys.
*/
`timescale 1ns/1ps
module sss_sequencer (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sleep_pin,
  input wire logic serial_variant,
  input wire logic [sss_pkg::CFG_W-1:0] config_pins,
  input wire sss_pkg::sss_host_wr_t host_wr,
  output logic drivers_on,
  output logic awake,
  output logic [1:0] power_state,
  output logic [sss_pkg::CFG_W-1:0] strap_config
);
  sss_pkg::sss_regs_t r;
  sss_pkg::sss_regs_t next_r;
  logic sleep_high;
  logic write_seen;
  logic write_one;
  logic write_zero;

  // Code shown on power_state for a state
  function automatic logic [1:0] power_code(
    input sss_pkg::sss_state_t st
  );
    logic [1:0] code;
    code = sss_pkg::PS_SLEEP;
    case (st)
      sss_pkg::SSS_SLEEP: begin
        code = sss_pkg::PS_SLEEP;
      end
      sss_pkg::SSS_STANDBY: begin
        code = sss_pkg::PS_STANDBY;
      end
      sss_pkg::SSS_ACTIVE: begin
        code = sss_pkg::PS_ACTIVE;
      end
      default: begin
        code = sss_pkg::PS_SLEEP;
      end
    endcase
    return code;
  endfunction : power_code

  // Awake in standby and active only
  function automatic logic state_awake(
    input sss_pkg::sss_state_t st
  );
    logic up;
    up = 1'h0;
    case (st)
      sss_pkg::SSS_SLEEP: begin
        up = 1'h0;
      end
      sss_pkg::SSS_STANDBY: begin
        up = 1'h1;
      end
      sss_pkg::SSS_ACTIVE: begin
        up = 1'h1;
      end
      default: begin
        up = 1'h0;
      end
    endcase
    return up;
  endfunction : state_awake

  // Gate drivers run in the active state only
  function automatic logic state_drives(
    input sss_pkg::sss_state_t st
  );
    logic drive;
    drive = 1'h0;
    case (st)
      sss_pkg::SSS_SLEEP: begin
        drive = 1'h0;
      end
      sss_pkg::SSS_STANDBY: begin
        drive = 1'h0;
      end
      sss_pkg::SSS_ACTIVE: begin
        drive = 1'h1;
      end
      default: begin
        drive = 1'h0;
      end
    endcase
    return drive;
  endfunction : state_drives

  // Host writes count only while awake on the serial variant
  function automatic logic write_taken(
    input sss_pkg::sss_state_t st,
    input logic serial
  );
    logic taken;
    taken = 1'h0;
    case (st)
      sss_pkg::SSS_SLEEP: begin
        taken = 1'h0;
      end
      sss_pkg::SSS_STANDBY: begin
        taken = serial;
      end
      sss_pkg::SSS_ACTIVE: begin
        taken = serial;
      end
      default: begin
        taken = 1'h0;
      end
    endcase
    return taken;
  endfunction : write_taken

  // Next stored enable bit; sleep always clears it
  function automatic logic enable_next(
    input sss_pkg::sss_state_t st,
    input logic awake_req,
    input logic taken,
    input logic value,
    input logic held
  );
    logic en;
    en = held;
    if (!awake_req) begin
      en = 1'h0;
    end else begin
      case (st)
        sss_pkg::SSS_SLEEP: begin
          en = 1'h0;
        end
        sss_pkg::SSS_STANDBY: begin
          if (taken) begin
            en = value;
          end
        end
        sss_pkg::SSS_ACTIVE: begin
          if (taken) begin
            en = value;
          end
        end
        default: begin
          en = 1'h0;
        end
      endcase
    end
    return en;
  endfunction : enable_next

  // Only the second sync stage is read
  assign sleep_high = r.sleep_sync[1];
  assign write_seen = host_wr.wr_valid &&
                      write_taken(r.state, serial_variant);
  assign write_one = write_seen && host_wr.driver_enable_bit;
  assign write_zero = write_seen && !host_wr.driver_enable_bit;

  always_comb begin
    next_r = r;
    next_r.sleep_sync = {r.sleep_sync[0], sleep_pin};
    next_r.cfg_s1 = config_pins;
    next_r.cfg_s2 = r.cfg_s1;
    next_r.driver_enable_bit = enable_next(r.state, sleep_high,
                                           write_seen,
                                           host_wr.driver_enable_bit,
                                           r.driver_enable_bit);
    case (r.state)
      sss_pkg::SSS_SLEEP: begin
        if (sleep_high) begin
          next_r.state = sss_pkg::SSS_STANDBY;
        end
      end
      sss_pkg::SSS_STANDBY: begin
        if (!sleep_high) begin
          next_r.state = sss_pkg::SSS_SLEEP;
        end else if (!serial_variant) begin
          next_r.cfg = r.cfg_s2;
          next_r.state = sss_pkg::SSS_ACTIVE;
        end else if (write_one) begin
          next_r.state = sss_pkg::SSS_ACTIVE;
        end
      end
      sss_pkg::SSS_ACTIVE: begin
        if (!sleep_high) begin
          next_r.state = sss_pkg::SSS_SLEEP;
        end else if (write_zero) begin
          next_r.state = sss_pkg::SSS_STANDBY;
        end
      end
      default: begin
        next_r.state = sss_pkg::SSS_SLEEP;
      end
    endcase
    next_r.awake = state_awake(next_r.state);
    next_r.drivers_on = state_drives(next_r.state);
    next_r.power_state = power_code(next_r.state);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r.sleep_sync <= sss_pkg::SYNC_RESET;
      r.state <= sss_pkg::SSS_SLEEP;
      r.driver_enable_bit <= 1'h0;
      r.drivers_on <= 1'h0;
      r.awake <= 1'h0;
      r.cfg <= sss_pkg::CFG_RESET;
      r.cfg_s1 <= sss_pkg::CFG_RESET;
      r.cfg_s2 <= sss_pkg::CFG_RESET;
      r.power_state <= sss_pkg::PS_SLEEP;
    end else begin
      r <= next_r;
    end
  end

  // Every output comes straight from its own register in r
  assign drivers_on = r.drivers_on;
  assign awake = r.awake;
  assign strap_config = r.cfg;
  assign power_state = r.power_state;
endmodule : sss_sequencer

// [include/sss_pkg.sv]
/*
 Shared types and constants of the sleep, standby and active sequencer.
 Assumes a single 40 MHz clock and a synchronous active-high reset.
*/
package sss_pkg;
  localparam int CFG_W = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h0;
  localparam logic [1:0] PS_SLEEP = 2'h0;
  localparam logic [1:0] PS_STANDBY = 2'h1;
  localparam logic [1:0] PS_ACTIVE = 2'h2;

  typedef enum logic [2:0] {
    SSS_SLEEP = 3'h1,
    SSS_STANDBY = 3'h2,
    SSS_ACTIVE = 3'h4
  } sss_state_t;

  typedef struct packed {
    logic wr_valid;
    logic driver_enable_bit;
  } sss_host_wr_t;

  typedef struct packed {
    logic [1:0] sleep_sync;
    sss_state_t state;
    logic driver_enable_bit;
    logic drivers_on;
    logic awake;
    logic [CFG_W-1:0] cfg;
    logic [CFG_W-1:0] cfg_s1;
    logic [CFG_W-1:0] cfg_s2;
    logic [1:0] power_state;
  } sss_regs_t;
endpackage : sss_pkg

// [tb/sss_host_model.sv]
/* Host model: drives the sleep pin and enable-bit writes.
 Assumes callers step on clk_sys. */
`timescale 1ns/1ps
module sss_host_model(
  input wire logic clk_sys,
  output logic sleep_pin = 1'b0,
  output sss_pkg::sss_host_wr_t host_wr = '0
);
  task pin(input logic v);
    @(posedge clk_sys) sleep_pin <= v;
  endtask : pin
  task wr(input logic v);
    @(posedge clk_sys) host_wr <= '{1'b1, v};
    @(posedge clk_sys) host_wr <= '0;
  endtask : wr
endmodule : sss_host_model

// [tb/sss_sequencer_sva.sv]
/* Port checker of the sequencer.
 Assumes the bind below. */
`timescale 1ns/1ps
module sss_sequencer_sva(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sleep_pin,
  input wire logic serial_variant,
  input wire sss_pkg::sss_host_wr_t host_wr,
  input wire logic drivers_on,
  input wire logic awake,
  input wire logic [1:0] power_state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  asleep_off_a: assert property (
    !awake |-> !drivers_on && power_state == sss_pkg::PS_SLEEP
  ) else $error("outputs not idle while asleep");
  no_talk_a: assert property (
    !awake && host_wr.wr_valid |=> !drivers_on
  ) else $error("write acted while asleep");
  wake_up_a: assert property (
    $rose(sleep_pin) |-> ##[2:4] awake
  ) else $error("no wake after sleep pin rise");
  strap_act_a: assert property (
    awake && !serial_variant |->
      ##[0:1] power_state == sss_pkg::PS_ACTIVE && drivers_on
  ) else $error("strap variant not active");
  serial_off_a: assert property (
    serial_variant && $rose(awake) |-> !drivers_on
  ) else $error("serial variant woke with drivers on");
  standby_off_a: assert property (
    power_state == sss_pkg::PS_STANDBY |-> !drivers_on && awake
  ) else $error("drivers on in standby");
  en_write_a: assert property (
    serial_variant && $rose(drivers_on) |->
      $past(host_wr.wr_valid && host_wr.driver_enable_bit)
  ) else $error("drivers on without enable write");
  sleep_back_a: assert property (
    !sleep_pin [*5] |-> !drivers_on && !awake
  ) else $error("no return to sleep");
endmodule : sss_sequencer_sva
bind sss_sequencer sss_sequencer_sva u_sss_sequencer_sva (
  .clk_sys(clk_sys),
  .reset(reset),
  .sleep_pin(sleep_pin),
  .serial_variant(serial_variant),
  .host_wr(host_wr),
  .drivers_on(drivers_on),
  .awake(awake),
  .power_state(power_state)
);

// [tb/sss_sequencer_test.sv]
/* Bench: strap and serial wake, enable and sleep.
 Assumes the host model drives the pin side. */
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
  tests_run++; \
  if ((a) !== (e)) begin \
    err_count++; \
    $display("BAD %s exp %h got %h", n, e, a); \
  end \
end
module sss_sequencer_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic sv = 1'b0;
  logic sp;
  logic on;
  logic aw;
  logic [7:0] cp = 8'h00;
  logic [7:0] sc;
  logic [1:0] ps;
  sss_pkg::sss_host_wr_t hw;
  int err_count = 0;
  int tests_run = 0;
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  sss_host_model u_sss_host_model (
    .clk_sys(clk_sys),
    .sleep_pin(sp),
    .host_wr(hw)
  );
  sss_sequencer u_sss_sequencer (
    .clk_sys(clk_sys),
    .reset(reset),
    .sleep_pin(sp),
    .serial_variant(sv),
    .config_pins(cp),
    .host_wr(hw),
    .drivers_on(on),
    .awake(aw),
    .power_state(ps),
    .strap_config(sc)
  );
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  task report_and_stop;
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task strap_test(input logic [7:0] straps);
    @(posedge clk_sys) cp <= straps;
    u_sss_host_model.pin(1'b1);
    wt(5);
    `CHK("ps", 2'h2, ps)
    `CHK("on", 1'b1, on)
    `CHK("sc", straps, sc)
    u_sss_host_model.wr(1'b0);
    wt(1);
    `CHK("ps", 2'h2, ps)
    u_sss_host_model.pin(1'b0);
    wt(5);
    `CHK("on", 1'b0, on)
    `CHK("ps", 2'h0, ps)
  endtask : strap_test
  task serial_test;
    logic [7:0] held;
    held = sc;
    @(posedge clk_sys) sv <= 1'b1;
    u_sss_host_model.wr(1'b1);
    wt(2);
    `CHK("on", 1'b0, on)
    `CHK("ps", 2'h0, ps)
    u_sss_host_model.pin(1'b1);
    wt(5);
    `CHK("ps", 2'h1, ps)
    `CHK("on", 1'b0, on)
    u_sss_host_model.wr(1'b1);
    wt(1);
    `CHK("on", 1'b1, on)
    `CHK("ps", 2'h2, ps)
    `CHK("sc", held, sc)
    u_sss_host_model.wr(1'b0);
    wt(1);
    `CHK("on", 1'b0, on)
    `CHK("ps", 2'h1, ps)
    u_sss_host_model.wr(1'b1);
    wt(1);
    `CHK("on", 1'b1, on)
    @(posedge clk_sys) reset <= 1'b1;
    wt(2);
    `CHK("on", 1'b0, on)
    `CHK("aw", 1'b0, aw)
    `CHK("ps", 2'h0, ps)
    @(posedge clk_sys) reset <= 1'b0;
    wt(5);
    `CHK("ps", 2'h1, ps)
    `CHK("on", 1'b0, on)
    u_sss_host_model.pin(1'b0);
    wt(5);
    `CHK("aw", 1'b0, aw)
    `CHK("ps", 2'h0, ps)
  endtask : serial_test
  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    strap_test(8'hA5);
    strap_test(8'h3C);
    serial_test;
    report_and_stop;
  end
  initial begin
    #10000;
    err_count++;
    report_and_stop;
  end
endmodule : sss_sequencer_test
